// file: core/ext_bus_if.sv
// Expanded-mode external bus interface with address, data and chip-select ports
//
// Operation
// - Wait input sampled high at bus clock rise holds clock high four osc cycles.
// - Wait sampled low: bus clock falls two osc cycles after rising.
// - Address valid in bus clock low phase; data bus used in high phase.
// - Bus clock is oscillator input divided by four.
// - Data strobe output is always the inverse of the bus clock.
// - Read/write line gives transfer direction in expanded and test modes.
// - High address port: outputs in single-chip, address 15..8 in expanded.
// - Low address port: outputs in single-chip, address 7..0 in expanded.
// - Data port: general I/O with direction register, or data bus when expanded.
// - Mode pins held during reset are latched to choose the operating mode.
// - After reset first mode pin becomes open-drain instruction-start pulse output.
// - With chip selects enabled, upper four port G pins carry the selects.
//
// The implementer's own choice: the address-and-strobe port.
`default_nettype none
module ext_bus_if
  import ext_bus_pkg::*;
(
  // Clock (oscillator input rate) and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Internal bus master requests
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic cpu_ack,
  output logic [7:0] cpu_rdata,
  input wire logic cpu_instr_start,
  // Bus control pins
  output logic bus_clk,
  output logic data_strobe_n,
  output logic read_write,
  input wire logic bus_wait,
  // Mode straps; first one doubles as instruction-start open-drain output
  input wire logic boot_mode_a,
  input wire logic boot_mode_b,
  output logic instr_start_n_out,
  output logic instr_start_n_oe_n,
  // Address and data pins
  output logic [7:0] high_addr_pin,
  output logic [7:0] low_addr_pin,
  input wire logic [7:0] data_pin_in,
  output logic [7:0] data_pin_out,
  output logic [7:0] data_pin_oe_n,
  // Port G sharing with chip selects
  input wire logic cs_enable,
  input wire logic [3:0] cs_select_n,
  input wire logic [7:0] gp_g_out,
  input wire logic [7:0] gp_g_oe_n,
  output logic [7:0] chip_select_port_pin_out,
  output logic [7:0] chip_select_port_pin_oe_n
);

  typedef struct packed {
    bus_phase_t phase;
    logic [1:0] cnt;
    logic e_clk;
    logic strobe_n;
    logic rw;
    logic wait_hold;
    logic active;
    logic act_we;
    logic [7:0] act_wdata;
    logic [7:0] hi_pin;
    logic [7:0] lo_pin;
    logic [7:0] dat_out;
    logic [7:0] dat_oe_n;
    logic ack;
    logic [7:0] rdata;
    logic [7:0] reg_rdata;
    logic [7:0] hi_reg;
    logic [7:0] lo_reg;
    logic [7:0] dat_reg;
    logic [7:0] dir_reg;
    logic [1:0] mode;
    logic [2:0] instr_cnt;
    logic instr_oe_n;
    logic instr_out;
    logic [7:0] cs_port_out;
    logic [7:0] cs_port_oe_n;
  } state_t;

  state_t st;
  state_t next_st;
  logic expanded;
  logic falling;
  logic [7:0] port_read;

  // Expanded and test modes both open the external bus
  assign expanded = st.mode[MODE_A_BIT];
  // Input bits read the pin, output bits read the latch
  assign port_read = (st.dir_reg & st.dat_reg) | (~st.dir_reg & data_pin_in);

  // Next-state logic for the whole block
  always_comb begin
    next_st = st;
    falling = 1'b0;
    next_st.ack = 1'b0;
    next_st.rdata = ZERO8;
    next_st.reg_rdata = ZERO8;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_HIGH_ADDR_PORT: next_st.hi_reg = reg_wdata;
        OFS_LOW_ADDR_PORT: next_st.lo_reg = reg_wdata;
        OFS_DATA_PORT: next_st.dat_reg = reg_wdata;
        OFS_DATA_PORT_DIR: next_st.dir_reg = reg_wdata;
        default: next_st.reg_rdata = ZERO8;
      endcase
    end

    // Register reads, answered next cycle; unmapped reads give zero
    if (reg_rd) begin
      case (reg_addr)
        OFS_HIGH_ADDR_PORT: next_st.reg_rdata = st.hi_reg;
        OFS_LOW_ADDR_PORT: next_st.reg_rdata = st.lo_reg;
        OFS_DATA_PORT: next_st.reg_rdata = expanded ? st.dat_reg : port_read;
        OFS_DATA_PORT_DIR: next_st.reg_rdata = st.dir_reg;
        default: next_st.reg_rdata = ZERO8;
      endcase
    end

    // Bus clock divider with wait stretch
    case (st.phase)
      PH_LOW: begin
        if (st.cnt == LOW_LAST) begin
          next_st.phase = PH_HIGH;
          next_st.cnt = 2'h0;
          next_st.e_clk = 1'b1;
          next_st.wait_hold = bus_wait;
          // Write data goes out only in the high phase
          if (expanded && st.active && st.act_we) begin
            next_st.dat_out = st.act_wdata;
            next_st.dat_oe_n = ZERO8;
          end
        end else begin
          next_st.cnt = st.cnt + CNT_STEP;
        end
      end
      PH_HIGH: begin
        if (st.cnt == HIGH_LAST) begin
          next_st.cnt = 2'h0;
          if (st.wait_hold) begin
            next_st.phase = PH_STRETCH;
          end else begin
            falling = 1'b1;
          end
        end else begin
          next_st.cnt = st.cnt + CNT_STEP;
        end
      end
      PH_STRETCH: begin
        if (st.cnt == STRETCH_LAST) begin
          next_st.cnt = 2'h0;
          falling = 1'b1;
        end else begin
          next_st.cnt = st.cnt + CNT_STEP;
        end
      end
      default: begin
        next_st.phase = PH_LOW;
        next_st.cnt = 2'h0;
      end
    endcase

    // Falling edge ends one transfer or starts the next; never both
    if (falling) begin
      next_st.phase = PH_LOW;
      next_st.e_clk = 1'b0;
      if (st.active) begin
        // Read data captured at the fall, where the far end holds it valid
        next_st.ack = 1'b1;
        next_st.rdata = st.act_we ? ZERO8 : data_pin_in;
        next_st.active = 1'b0;
        next_st.rw = 1'b1;
        next_st.dat_oe_n = ALL_ONES8;
      end else if (cpu_req && expanded) begin
        // Address is set at the fall so it is settled through the low phase
        next_st.active = 1'b1;
        next_st.act_we = cpu_we;
        next_st.act_wdata = cpu_wdata;
        next_st.hi_pin = cpu_addr[15:8];
        next_st.lo_pin = cpu_addr[7:0];
        next_st.rw = ~cpu_we;
      end
    end

    // Single-chip: address ports and data port are plain I/O
    if (!expanded) begin
      next_st.hi_pin = st.hi_reg;
      next_st.lo_pin = st.lo_reg;
      next_st.dat_out = st.dat_reg;
      next_st.dat_oe_n = ~st.dir_reg;
      next_st.rw = 1'b1;
      next_st.active = 1'b0;
    end

    next_st.strobe_n = ~next_st.e_clk;

    // Instruction-start pulse, one bus cycle wide; a retrigger restarts the count
    if (cpu_instr_start) begin
      next_st.instr_cnt = INSTR_LAST;
      next_st.instr_oe_n = 1'b0;
    end else if (st.instr_cnt != 3'h0) begin
      next_st.instr_cnt = st.instr_cnt - INSTR_STEP;
    end else begin
      next_st.instr_oe_n = 1'b1;
    end

    // Port G upper pins become chip selects when enabled
    next_st.cs_port_out = gp_g_out;
    next_st.cs_port_oe_n = gp_g_oe_n;
    if (cs_enable) begin
      next_st.cs_port_out[7:4] = cs_select_n;
      next_st.cs_port_oe_n[7:4] = 4'h0;
    end

    // Synchronous reset; mode straps caught while reset is held
    if (sys_rst) begin
      next_st = '0;
      next_st.phase = PH_LOW;
      next_st.strobe_n = 1'b1;
      next_st.rw = 1'b1;
      next_st.hi_reg = RST_PORT_DATA;
      next_st.lo_reg = RST_PORT_DATA;
      next_st.dat_reg = RST_PORT_DATA;
      next_st.dir_reg = RST_PORT_DIR;
      next_st.dat_oe_n = ALL_ONES8;
      next_st.cs_port_oe_n = ALL_ONES8;
      next_st.instr_oe_n = 1'b1; // Pin released so the strap can be read
      next_st.mode = {boot_mode_b, boot_mode_a};
    end
  end

  // State register
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // Outputs straight from the state register
  assign reg_rdata = st.reg_rdata;
  assign cpu_ack = st.ack;
  assign cpu_rdata = st.rdata;
  assign bus_clk = st.e_clk;
  assign data_strobe_n = st.strobe_n;
  assign read_write = st.rw;
  assign instr_start_n_out = st.instr_out;
  assign instr_start_n_oe_n = st.instr_oe_n;
  assign high_addr_pin = st.hi_pin;
  assign low_addr_pin = st.lo_pin;
  assign data_pin_out = st.dat_out;
  assign data_pin_oe_n = st.dat_oe_n;
  assign chip_select_port_pin_out = st.cs_port_out;
  assign chip_select_port_pin_oe_n = st.cs_port_oe_n;

  // Checks on bus timing and pin ownership
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_wait_stretch_hold: assert property (
    $rose(bus_clk) && $past(bus_wait) |-> bus_clk [*4] ##1 !bus_clk)
    else $error("bus clock not held high four cycles after wait");

  a_normal_fall_two: assert property (
    $rose(bus_clk) && !$past(bus_wait) |-> bus_clk [*2] ##1 !bus_clk)
    else $error("bus clock did not fall two cycles after rise");

  a_low_phase_len: assert property (
    $fell(bus_clk) |-> !bus_clk [*2] ##1 bus_clk)
    else $error("bus clock low phase is not two cycles");

  a_strobe_inverse: assert property (
    data_strobe_n == !bus_clk)
    else $error("data strobe is not the inverse of the bus clock");

  a_addr_change_fall: assert property (
    expanded && $changed(low_addr_pin) |-> $fell(bus_clk))
    else $error("address changed outside the bus clock fall");

  a_write_drives_high: assert property (
    expanded && bus_clk && !read_write |-> data_pin_oe_n == ZERO8)
    else $error("write cycle does not drive the data bus");

  a_data_released_low: assert property (
    expanded && !bus_clk |-> data_pin_oe_n == ALL_ONES8)
    else $error("data bus driven during low phase");

  a_single_chip_ports: assert property (
    !expanded |=> low_addr_pin == $past(st.lo_reg) && high_addr_pin == $past(st.hi_reg))
    else $error("single-chip address ports do not follow their latches");

  a_mode_stable_run: assert property (
    $stable(st.mode))
    else $error("operating mode changed outside reset");

  a_instr_pulse_width: assert property (
    $fell(instr_start_n_oe_n) |-> !instr_start_n_oe_n [*4])
    else $error("instruction-start pulse shorter than a bus cycle");

  a_cs_takeover: assert property (
    $past(cs_enable) |-> chip_select_port_pin_oe_n[7:4] == 4'h0 && chip_select_port_pin_out[7:4] == $past(cs_select_n))
    else $error("chip selects not on upper port G pins");

  // Bus timing and pin ownership per mode; a stray drive would fight the far end
  a_high_addr_fall: assert property (
    expanded && $changed(high_addr_pin) |-> $fell(bus_clk))
    else $error("high address changed outside the bus clock fall");

  a_read_no_drive: assert property (
    expanded && read_write |-> data_pin_oe_n == ALL_ONES8)
    else $error("data bus driven while read_write marks a read");

  a_ack_on_fall: assert property (
    cpu_ack |-> $fell(bus_clk))
    else $error("transfer ended away from the bus clock fall");

  a_single_chip_data: assert property (
    !expanded |=> data_pin_oe_n == ~$past(st.dir_reg) && data_pin_out == $past(st.dat_reg))
    else $error("single-chip data port does not follow its latches");

  a_rw_single_chip: assert property (
    !expanded |-> read_write)
    else $error("read_write left idle level in single-chip mode");

  a_instr_start_low: assert property (
    cpu_instr_start |=> !instr_start_n_oe_n)
    else $error("instruction-start pin not pulled low after start");

  c_wait_stretch: cover property ($rose(bus_clk) && $past(bus_wait));
  c_ext_write: cover property (cpu_ack && !$past(read_write));
  c_ext_read: cover property (cpu_ack && $past(read_write) && expanded);
  c_cs_enabled: cover property (cs_enable ##1 cs_enable);

endmodule : ext_bus_if
`default_nettype wire

// file: core/ext_bus_pkg.sv
// Constants, offsets and types for the non-multiplexed external bus interface
`default_nettype none
package ext_bus_pkg;
  // Register offsets in the control block
  localparam logic [15:0] OFS_HIGH_ADDR_PORT = 16'h1004;
  localparam logic [15:0] OFS_LOW_ADDR_PORT = 16'h1005;
  localparam logic [15:0] OFS_DATA_PORT = 16'h1006;
  localparam logic [15:0] OFS_DATA_PORT_DIR = 16'h1007;

  // Reset values of the port registers
  localparam logic [7:0] RST_PORT_DATA = 8'h00;
  localparam logic [7:0] RST_PORT_DIR = 8'h00;
  localparam logic [7:0] ALL_ONES8 = 8'hff;
  localparam logic [7:0] ZERO8 = 8'h00;

  // Bus clock timing in oscillator-input cycles
  localparam int OSC_PER_BUS = 4;
  localparam int LOW_CYC = OSC_PER_BUS / 2;
  localparam int HIGH_CYC = OSC_PER_BUS / 2;
  localparam int WAIT_HOLD_CYC = 4;
  localparam int STRETCH_CYC = WAIT_HOLD_CYC - HIGH_CYC;
  localparam logic [1:0] LOW_LAST = 2'(LOW_CYC - 1);
  localparam logic [1:0] HIGH_LAST = 2'(HIGH_CYC - 1);
  localparam logic [1:0] STRETCH_LAST = 2'(STRETCH_CYC - 1);
  localparam logic [1:0] CNT_STEP = 2'h1;

  // Instruction-start pulse width: one bus cycle
  localparam int INSTR_CYC = OSC_PER_BUS;
  localparam logic [2:0] INSTR_LAST = 3'(INSTR_CYC - 1);
  localparam logic [2:0] INSTR_STEP = 3'h1;

  // Mode strap encoding {mode_b, mode_a}
  localparam int MODE_A_BIT = 0;
  localparam int MODE_B_BIT = 1;
  localparam logic [1:0] MODE_SPECIAL_TEST = 2'h1;

  // Bus clock phase, one-hot
  typedef enum logic [2:0] {
    PH_LOW = 3'b001,
    PH_HIGH = 3'b010,
    PH_STRETCH = 3'b100
  } bus_phase_t;
endpackage : ext_bus_pkg
`default_nettype wire

// file: dv/ext_mem_model.sv
// Behavioural external memory hanging on the non-multiplexed bus
`default_nettype none
module ext_mem_model (
  // Clock and bus control
  input wire logic clk,
  input wire logic bus_clk,
  input wire logic read_write,
  input wire logic slow,
  output logic bus_wait,
  // Address and data
  input wire logic [7:0] low_addr_pin,
  input wire logic [7:0] data_pin_out,
  input wire logic [7:0] data_pin_oe_n,
  output logic [7:0] bus_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] last = 8'h00;

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end

  // Wait follows slow, held steady through each transfer, so the rise always samples one level
  assign bus_wait = slow;

  // Read data only in the high phase; otherwise a toggling pattern, never a stale byte
  assign bus_data = (bus_clk && read_write) ? mem[low_addr_pin] : ~last;

  // Write captured while the bus clock is high, before its fall
  always @(posedge clk) begin
    last <= bus_data;
    if (bus_clk && !read_write && data_pin_oe_n == 8'h00) mem[low_addr_pin] <= data_pin_out;
  end
endmodule : ext_mem_model
`default_nettype wire

// file: dv/tb.sv
// Self-checking testbench for the external bus interface
`default_nettype none
module tb import ext_bus_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cpu_req = 1'b0;
  logic cpu_we = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_wdata = 8'h00;
  logic cpu_instr_start = 1'b0;
  logic boot_mode_a = 1'b1;
  logic boot_mode_b = 1'b0;
  logic cs_enable = 1'b0;
  logic [3:0] cs_select_n = 4'hf;
  logic [7:0] gp_g_out = 8'h00;
  logic [7:0] gp_g_oe_n = 8'hff;
  logic slow = 1'b0;
  logic ext_drive = 1'b0;
  logic [7:0] pin_val = 8'h00;
  logic [7:0] reg_rdata, cpu_rdata, high_addr_pin, low_addr_pin, data_pin_in, data_pin_out, data_pin_oe_n;
  logic [7:0] model_in, chip_select_port_pin_out, chip_select_port_pin_oe_n;
  logic cpu_ack, bus_clk, data_strobe_n, read_write, bus_wait, instr_start_n_out, instr_start_n_oe_n;
  int mismatches = 0;
  int checks_done = 0;
  int seed = 32'h6059;

  always #5 clk = ~clk;
  // Testbench stands in for the pin in single-chip reads
  assign data_pin_in = ext_drive ? pin_val : model_in;

  ext_bus_if ext_bus_if_inst (
    .clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .cpu_instr_start(cpu_instr_start),
    .bus_clk(bus_clk), .data_strobe_n(data_strobe_n), .read_write(read_write), .bus_wait(bus_wait),
    .boot_mode_a(boot_mode_a), .boot_mode_b(boot_mode_b),
    .instr_start_n_out(instr_start_n_out), .instr_start_n_oe_n(instr_start_n_oe_n),
    .high_addr_pin(high_addr_pin), .low_addr_pin(low_addr_pin),
    .data_pin_in(data_pin_in), .data_pin_out(data_pin_out), .data_pin_oe_n(data_pin_oe_n),
    .cs_enable(cs_enable), .cs_select_n(cs_select_n), .gp_g_out(gp_g_out), .gp_g_oe_n(gp_g_oe_n),
    .chip_select_port_pin_out(chip_select_port_pin_out),
    .chip_select_port_pin_oe_n(chip_select_port_pin_oe_n)
  );
  ext_mem_model ext_mem_model_inst (
    .clk(clk), .bus_clk(bus_clk), .read_write(read_write), .slow(slow), .bus_wait(bus_wait),
    .low_addr_pin(low_addr_pin), .data_pin_out(data_pin_out), .data_pin_oe_n(data_pin_oe_n),
    .bus_data(model_in)
  );

  function automatic logic [7:0] port_read(input logic [7:0] latch, input logic [7:0] dir, input logic [7:0] pin);
    return (latch & dir) | (pin & ~dir);
  endfunction : port_read

  function automatic int high_len(input logic w);
    return w ? WAIT_HOLD_CYC : HIGH_CYC;
  endfunction : high_len

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // Strap boot_mode_a held through reset, then flipped to prove it was latched
  task automatic do_reset(input logic mode);
    @(posedge clk);
    sys_rst <= 1'b1;
    boot_mode_a <= mode;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    boot_mode_a <= ~mode;
    @(negedge clk);
    chk("rst clk", {bus_clk, data_strobe_n, instr_start_n_oe_n}, 16'h0003);
  endtask : do_reset

  task automatic reg_op(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge clk);
    q = reg_rdata;
  endtask : reg_op

  // One external transfer; request held until ack, dropped the cycle after
  task automatic xfer(input logic we, input logic [15:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
    int hi;
    logic rw;
    logic [7:0] oe;
    @(posedge clk);
    slow <= w;
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_addr <= a;
    cpu_wdata <= d;
    hi = 0;
    for (int n = 0; n < 40 && cpu_ack !== 1'b1; n++) begin
      @(negedge clk);
      hi = (bus_clk === 1'b1) ? hi + 1 : ((cpu_ack === 1'b1) ? hi : 0);
      if (bus_clk === 1'b1) begin
        rw = read_write;
        oe = data_pin_oe_n;
      end
    end
    chk("ack", cpu_ack, 16'h0001);
    if (cpu_ack !== 1'b1) stop_test;
    chk("high phase", 16'(hi), 16'(high_len(w)));
    chk("rw", rw ^ we, 16'h0001);
    chk("addr", {high_addr_pin, low_addr_pin}, a);
    chk("bus drive", oe, we ? ZERO8 : ALL_ONES8);
    chk("released", data_pin_oe_n, ALL_ONES8);
    q = cpu_rdata;
    @(posedge clk);
    cpu_req <= 1'b0;
  endtask : xfer

  initial begin
    logic [7:0] q;
    logic [7:0] d;
    logic [15:0] a;
    int n;
    do_reset(1'b1);
    // Reset values and read-back of every port register, plus an unmapped place
    for (int i = 0; i < 4; i++) begin
      a = OFS_HIGH_ADDR_PORT + 16'(i);
      d = 8'($random(seed));
      reg_op(1'b0, a, 8'h00, q);
      chk("reg reset", q, (i == 3) ? RST_PORT_DIR : RST_PORT_DATA);
      reg_op(1'b1, a, d, q);
      reg_op(1'b0, a, 8'h00, q);
      chk("reg rw", q, d);
    end
    reg_op(1'b1, 16'h1008, 8'h5a, q);
    reg_op(1'b0, 16'h1008, 8'h00, q);
    chk("unmapped", q, ZERO8);
    $display("test registers done");
    n = 0;
    repeat (16) begin
      @(negedge clk);
      n += (bus_clk === 1'b1);
      chk("strobe", data_strobe_n ^ bus_clk, 16'h0001);
    end
    chk("clk ratio", 16'(n), 16'(16 / OSC_PER_BUS * HIGH_CYC));
    $display("test bus clock done");
    // Random writes and reads, wait stretch alternating
    for (int i = 0; i < 8; i++) begin
      a = 16'($random(seed));
      d = 8'($random(seed));
      xfer(1'b1, a, d, i[0], q);
      chk("mem write", ext_mem_model_inst.mem[a[7:0]], d);
      xfer(1'b0, a, 8'h00, ~i[0], q);
      chk("read data", q, d);
    end
    $display("test transfers done");
    @(posedge clk);
    cpu_instr_start <= 1'b1;
    @(posedge clk);
    cpu_instr_start <= 1'b0;
    n = 0;
    repeat (8) begin
      @(negedge clk);
      n += (instr_start_n_oe_n === 1'b0);
    end
    chk("instr pulse", 16'(n), 16'(OSC_PER_BUS));
    chk("open drain", instr_start_n_out, 16'h0000);
    for (int i = 1; i >= 0; i--) begin
      @(posedge clk);
      cs_enable <= i[0];
      cs_select_n <= 4'h5;
      gp_g_out <= 8'h3c;
      gp_g_oe_n <= 8'hf3;
      repeat (2) @(negedge clk);
      chk("cs out", chip_select_port_pin_out, i[0] ? 8'h5c : 8'h3c);
      chk("cs oe", chip_select_port_pin_oe_n, i[0] ? 8'h03 : 8'hf3);
    end
    $display("test strobe and selects done");
    // Single-chip: address ports are plain outputs, data port follows its direction register, and bus requests go unanswered
    do_reset(1'b0);
    reg_op(1'b1, OFS_HIGH_ADDR_PORT, 8'hc3, q);
    reg_op(1'b1, OFS_LOW_ADDR_PORT, 8'h96, q);
    reg_op(1'b1, OFS_DATA_PORT, 8'ha5, q);
    reg_op(1'b1, OFS_DATA_PORT_DIR, 8'hf0, q);
    @(posedge clk);
    ext_drive <= 1'b1;
    pin_val <= 8'h3c;
    cpu_req <= 1'b1;
    cpu_we <= 1'b1;
    repeat (2) @(negedge clk);
    chk("high port", high_addr_pin, 8'hc3);
    chk("low port", low_addr_pin, 8'h96);
    chk("dir", data_pin_oe_n, 8'h0f);
    chk("data out", data_pin_out, 8'ha5);
    reg_op(1'b0, OFS_DATA_PORT, 8'h00, q);
    chk("pin read", q, port_read(8'ha5, 8'hf0, 8'h3c));
    n = 0;
    repeat (20) begin
      @(negedge clk);
      n += (cpu_ack === 1'b1);
    end
    chk("no ack", 16'(n), 16'h0000);
    chk("rw idle", read_write, 16'h0001);
    @(posedge clk);
    cpu_req <= 1'b0;
    $display("test single chip done");
    stop_test;
  end
endmodule : tb
`default_nettype wire
